//--- core/jcmd_top.sv
// Jack clamp, switch and mic impedance detect controller with AXI4-Lite registers
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ns
`include "jcmd_params.svh"
module jcmd_top
  import jcmd_pkg::*;
#(
  parameter int unsigned INTERVAL_BASE_CYC = `JCMD_BASE_CYC,
  parameter int ADDR_W = 14
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic jack_sense,
  input wire logic general_input_line,
  input wire logic meas_done,
  input wire logic [2:0] meas_level,
  input wire logic [6:0] meas_adc,
  output logic clamp_active,
  output logic switch_closed,
  output logic meas_start,
  output logic meas_pin_sel,
  output logic meas_adc_mode,
  output logic [1:0] meas_ref_sel,
  output logic [2:0] bias_enable,
  output logic [7:0] level_enable_mask
);
  ////////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers
  logic [1:0] rst_pipe;
  logic rst_int_b;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_int_b = rst_pipe[1];

  logic [12:0] pins_s;
  logic done_d;
  logic done_pulse;
  jcmd_level_t lvl_s;
  jcmd_adc_t adc_s;

  jcmd_sync #(.W(13)) u_sync (
    .core_clk(core_clk),
    .rst_b(rst_int_b),
    .async_in({general_input_line, jack_sense, meas_done, meas_level, meas_adc}),
    .sync_out(pins_s)
  );
  assign adc_s = pins_s[6:0];
  assign lvl_s = pins_s[9:7];

  always_ff @(posedge core_clk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      done_d <= 1'b0;
    end else begin
      done_d <= pins_s[10];
    end
  end
  assign done_pulse = pins_s[10] && !done_d;

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  logic [3:0] clamp_mode;
  logic [1:0] switch_mode;
  logic db_jack;
  logic db_clamp;
  logic [2:0] detect_mode_select;
  logic detect_pin_select;
  logic [3:0] measure_interval;
  logic [1:0] detect_reference_select;
  logic debounce_count;
  logic detect_enable;

  logic aw_held;
  logic w_held;
  logic [11:0] aw_idx;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic [15:0] wr_val;

  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [15:0] new_v,
                                          input logic [1:0] strb);
    merge16 = {strb[1] ? new_v[15:8] : old_v[15:8], strb[0] ? new_v[7:0] : old_v[7:0]};
  endfunction

  function automatic logic idx_hit(input logic [11:0] idx);
    idx_hit = idx == `JCMD_IDX_CLAMP || idx == `JCMD_IDX_SWITCH ||
              idx == `JCMD_IDX_RAW_STS || idx == `JCMD_IDX_DEBOUNCE ||
              idx == `JCMD_IDX_ACC_MODE || idx == `JCMD_IDX_DET_CTRL ||
              idx == `JCMD_IDX_LVL_MASK || idx == `JCMD_IDX_DET_STS ||
              idx == `JCMD_IDX_ADC;
  endfunction

  logic [15:0] cur_val;
  localparam logic [15:0] CTRL_RST = `JCMD_CTRL_RESET;

  always_comb begin
    unique case (aw_idx)
      `JCMD_IDX_CLAMP: cur_val = {12'h000, clamp_mode};
      `JCMD_IDX_SWITCH: cur_val = {14'h0000, switch_mode};
      `JCMD_IDX_DEBOUNCE: cur_val = {12'h000, db_clamp, 2'h0, db_jack};
      `JCMD_IDX_ACC_MODE: cur_val = {2'h0, detect_pin_select, 10'h000, detect_mode_select};
      `JCMD_IDX_DET_CTRL: cur_val = {4'h0, measure_interval, 2'h0, detect_reference_select,
                                     2'h0, debounce_count, detect_enable};
      `JCMD_IDX_LVL_MASK: cur_val = {8'h00, level_enable_mask};
      default: cur_val = 16'h0000;
    endcase
  end

  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign wr_val = merge16(cur_val, w_data[15:0], w_strb[1:0]);

  always_ff @(posedge core_clk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      clamp_mode <= 4'h0;
      switch_mode <= 2'h0;
      db_jack <= 1'b0;
      db_clamp <= 1'b0;
      detect_mode_select <= `JCMD_MODE_DISCRETE;
      detect_pin_select <= 1'b0;
      {measure_interval, detect_reference_select} <= {CTRL_RST[11:8], CTRL_RST[5:4]};
      {debounce_count, detect_enable} <= CTRL_RST[1:0];
      level_enable_mask <= `JCMD_LVL_MASK_RESET;
    end else if (wr_fire) begin
      unique case (aw_idx)
        `JCMD_IDX_CLAMP: clamp_mode <= wr_val[3:0];
        `JCMD_IDX_SWITCH: switch_mode <= wr_val[1:0];
        `JCMD_IDX_DEBOUNCE: begin
          db_jack <= wr_val[`JCMD_DB_JACK_BIT];
          db_clamp <= wr_val[`JCMD_DB_CLAMP_BIT];
        end
        `JCMD_IDX_ACC_MODE: begin
          detect_mode_select <= wr_val[2:0];
          detect_pin_select <= wr_val[`JCMD_ACC_PIN_BIT];
        end
        `JCMD_IDX_DET_CTRL: begin
          measure_interval <= wr_val[`JCMD_CTRL_RATE_LSB +: 4];
          detect_reference_select <= wr_val[`JCMD_CTRL_REF_LSB +: 2];
          debounce_count <= wr_val[`JCMD_CTRL_DBT_BIT];
          detect_enable <= wr_val[`JCMD_CTRL_ENA_BIT];
        end
        `JCMD_IDX_LVL_MASK: level_enable_mask <= wr_val[7:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write and read channels
  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge core_clk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      aw_held <= 1'b0;
      aw_idx <= 12'h000;
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_idx <= 12'(s_axi_awaddr[ADDR_W-1:2]);
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= idx_hit(aw_idx) ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  logic result_valid;
  logic detect_state;
  jcmd_level_t level_code;
  jcmd_adc_t adc_result;
  jcmd_adc_t adc_result_delta;
  logic [11:0] ar_idx;
  logic [15:0] rd_val;

  assign ar_idx = 12'(s_axi_araddr[ADDR_W-1:2]);

  always_comb begin
    unique case (ar_idx)
      `JCMD_IDX_CLAMP: rd_val = {12'h000, clamp_mode};
      `JCMD_IDX_SWITCH: rd_val = {14'h0000, switch_mode};
      `JCMD_IDX_RAW_STS: rd_val = {14'h0000, clamp_active, pins_s[11]};
      `JCMD_IDX_DEBOUNCE: rd_val = {12'h000, db_clamp, 2'h0, db_jack};
      `JCMD_IDX_ACC_MODE: rd_val = {2'h0, detect_pin_select, 10'h000, detect_mode_select};
      `JCMD_IDX_DET_CTRL: rd_val = {4'h0, measure_interval, 2'h0, detect_reference_select,
                                    2'h0, debounce_count, detect_enable};
      `JCMD_IDX_LVL_MASK: rd_val = {8'h00, level_enable_mask};
      `JCMD_IDX_DET_STS: rd_val = {11'h000, level_code, detect_state, result_valid};
      `JCMD_IDX_ADC: rd_val = {1'b0, adc_result_delta, 1'b0, adc_result};
      default: rd_val = 16'h0000;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {16'h0000, rd_val};
      s_axi_rresp <= idx_hit(ar_idx) ? 2'h0 : 2'h2;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clamp and switch
  jcmd_clamp u_clamp (
    .core_clk(core_clk),
    .rst_b(rst_int_b),
    .raw_in(pins_s[12:11]),
    .db_enable(db_clamp),
    .clamp_mode(clamp_mode),
    .switch_mode(switch_mode),
    .clamp_active(clamp_active),
    .switch_closed(switch_closed)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Measurement sequencer
  logic run;
  logic adc_mode;
  jcmd_seq_t seq_state;
  logic [22:0] wait_cnt;
  logic [22:0] wait_len;
  logic [3:0] shift;

  assign adc_mode = detect_mode_select == `JCMD_MODE_ADC;
  // Other mode codes belong to other detect functions, so nothing runs here
  assign run = detect_enable && (adc_mode ||
               detect_mode_select == `JCMD_MODE_DISCRETE);
  assign meas_pin_sel = detect_pin_select;
  assign meas_adc_mode = adc_mode;
  assign meas_ref_sel = detect_reference_select;
  // Code 00 is the supply rail and needs no bias output
  for (genvar b = 0; b < 3; b++) begin : g_bias
    assign bias_enable[b] = run && detect_reference_select == 2'(b + 1);
  end

  assign shift = (measure_interval >= 4'hc) ? 4'(`JCMD_RATE_MAX_SHIFT)
                                            : measure_interval - 4'h1;
  assign wait_len = 23'(INTERVAL_BASE_CYC) << shift;

  always_ff @(posedge core_clk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      seq_state <= JCMD_S_IDLE;
      wait_cnt <= '0;
      meas_start <= 1'b0;
    end else begin
      meas_start <= 1'b0;
      if (!run) begin
        seq_state <= JCMD_S_IDLE;
      end else begin
        unique case (seq_state)
          JCMD_S_IDLE: begin
            seq_state <= JCMD_S_MEAS;
            meas_start <= 1'b1;
          end
          JCMD_S_MEAS: if (done_pulse) begin
            if (measure_interval == 4'h0) begin
              meas_start <= 1'b1;
            end else begin
              seq_state <= JCMD_S_WAIT;
              wait_cnt <= wait_len - 23'h1;
            end
          end
          JCMD_S_WAIT: begin
            if (wait_cnt == '0) begin
              seq_state <= JCMD_S_MEAS;
              meas_start <= 1'b1;
            end else begin
              wait_cnt <= wait_cnt - 23'h1;
            end
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Results
  jcmd_level_t last_lvl;
  logic [2:0] match_cnt;
  logic [2:0] next_match;
  logic meas_in;

  assign meas_in = done_pulse && run && seq_state == JCMD_S_MEAS;
  assign next_match = (lvl_s == last_lvl && match_cnt != 3'h0) ?
                      ((match_cnt == 3'h4) ? 3'h4 : match_cnt + 3'h1) : 3'h1;

  always_ff @(posedge core_clk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      result_valid <= 1'b0;
      detect_state <= 1'b0;
      level_code <= '0;
      last_lvl <= '0;
      match_cnt <= 3'h0;
      adc_result <= '0;
      adc_result_delta <= '0;
    end else if (!detect_enable) begin
      result_valid <= 1'b0;
      match_cnt <= 3'h0;
    end else if (meas_in && adc_mode) begin
      adc_result <= adc_s;
      adc_result_delta <= adc_s - adc_result;
      result_valid <= 1'b1;
    end else if (meas_in) begin
      last_lvl <= lvl_s;
      match_cnt <= next_match;
      if (next_match >= (debounce_count ? 3'h4 : 3'h2)) begin
        level_code <= lvl_s;
        // Level zero is the no-accessory level
        detect_state <= lvl_s != 3'h0;
        result_valid <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_clamp_off: assert property (@(posedge core_clk) disable iff (!rst_int_b)
    clamp_mode == 4'h0 |-> !clamp_active) else $error("clamp on in mode 0");
  a_clamp_forced: assert property (@(posedge core_clk) disable iff (!rst_int_b)
    clamp_mode == 4'h1 |-> clamp_active) else $error("clamp off in mode 1");
  a_switch_inverse: assert property (@(posedge core_clk) disable iff (!rst_int_b)
    switch_mode == 2'h3 |-> switch_closed == !clamp_active)
    else $error("switch not inverse of clamp");
  a_seq_gate: assert property (@(posedge core_clk) disable iff (!rst_int_b)
    !run |=> seq_state == JCMD_S_IDLE && !meas_start)
    else $error("sequencer active while not enabled");
  a_valid_drop: assert property (@(posedge core_clk) disable iff (!rst_int_b)
    !detect_enable |=> !result_valid) else $error("valid kept after disable");
  a_valid_hold: assert property (@(posedge core_clk) disable iff (!rst_int_b)
    result_valid && detect_enable |=> result_valid) else $error("valid lost");
  a_bias_auto: assert property (@(posedge core_clk) disable iff (!rst_int_b)
    run && detect_reference_select == 2'h2 |-> bias_enable == 3'h2)
    else $error("wrong bias enabled");
  a_rate_continuous: assert property (@(posedge core_clk) disable iff (!rst_int_b)
    meas_in && measure_interval == 4'h0 |=> meas_start && seq_state == JCMD_S_MEAS)
    else $error("continuous mode did not restart");
endmodule // jcmd_top

//--- core/jcmd_params.svh
// Constants for the jack clamp and mic detect controller
`ifndef JCMD_PARAMS_SVH
`define JCMD_PARAMS_SVH
// Register indices; byte address is four times the index
`define JCMD_IDX_CLAMP 12'h2a2
`define JCMD_IDX_SWITCH 12'hc18
`define JCMD_IDX_RAW_STS 12'hd55
`define JCMD_IDX_DEBOUNCE 12'hd56
`define JCMD_IDX_ACC_MODE 12'h293
`define JCMD_IDX_DET_CTRL 12'h2a3
`define JCMD_IDX_LVL_MASK 12'h2a4
`define JCMD_IDX_DET_STS 12'h2a5
`define JCMD_IDX_ADC 12'h2a6
// Field positions
`define JCMD_STS_JACK_BIT 0
`define JCMD_STS_CLAMP_BIT 1
`define JCMD_DB_JACK_BIT 0
`define JCMD_DB_CLAMP_BIT 3
`define JCMD_ACC_PIN_BIT 13
`define JCMD_CTRL_ENA_BIT 0
`define JCMD_CTRL_DBT_BIT 1
`define JCMD_CTRL_REF_LSB 4
`define JCMD_CTRL_RATE_LSB 8
`define JCMD_ADC_DELTA_LSB 8
// Reset values
`define JCMD_CTRL_RESET 16'h0102
`define JCMD_LVL_MASK_RESET 8'hff
// Mode codes
`define JCMD_MODE_DISCRETE 3'h0
`define JCMD_MODE_ADC 3'h7
// Timing
`define JCMD_CLK_NS 100
`define JCMD_TICK32_NS 30518
`define JCMD_TICK32_CYC (`JCMD_TICK32_NS / `JCMD_CLK_NS)
`define JCMD_DB_TICKS 4
`define JCMD_BASE_NS 250000
`define JCMD_BASE_CYC (`JCMD_BASE_NS / `JCMD_CLK_NS)
`define JCMD_RATE_MAX_SHIFT 11
`endif

//--- core/jcmd_pkg.sv
// Types for the jack clamp and mic detect controller
package jcmd_pkg;
  typedef enum logic [1:0] {JCMD_S_IDLE, JCMD_S_MEAS, JCMD_S_WAIT} jcmd_seq_t;
  typedef logic [2:0] jcmd_level_t;
  typedef logic [6:0] jcmd_adc_t;
endpackage

//--- core/jcmd_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module jcmd_sync #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] stage1;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule // jcmd_sync

//--- core/jcmd_clamp.sv
// Clamp input debounce, clamp condition decode and switch control
`timescale 1ns/1ns
`include "jcmd_params.svh"
module jcmd_clamp
  import jcmd_pkg::*;
#(
  parameter int TICK_CYC = `JCMD_TICK32_CYC,
  parameter int DB_TICKS = `JCMD_DB_TICKS
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [1:0] raw_in,
  input wire logic db_enable,
  input wire logic [3:0] clamp_mode,
  input wire logic [1:0] switch_mode,
  output logic clamp_active,
  output logic switch_closed
);
  logic [15:0] tick_cnt;
  logic tick;
  logic [1:0] stable;

  // Slow tick stands in for the 32 kHz debounce clock
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else if (tick_cnt == 16'(TICK_CYC - 1)) begin
      tick_cnt <= '0;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 16'h0001;
      tick <= 1'b0;
    end
  end

  for (genvar i = 0; i < 2; i++) begin : g_db
    logic [3:0] db_cnt;
    always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
        db_cnt <= '0;
        stable[i] <= 1'b0;
      end else if (!db_enable || raw_in[i] == stable[i]) begin
        db_cnt <= '0;
        stable[i] <= raw_in[i];
      end else if (tick) begin
        db_cnt <= db_cnt + 4'h1;
        if (db_cnt == 4'(DB_TICKS - 1)) begin
          stable[i] <= raw_in[i];
        end
      end
    end
  end

  logic j;
  logic g;
  assign j = stable[0];
  assign g = stable[1];

  always_comb begin
    unique case (clamp_mode)
      4'h0: clamp_active = 1'b0;
      4'h1: clamp_active = 1'b1;
      4'h4: clamp_active = !j;
      4'h5: clamp_active = j;
      4'h6: clamp_active = !g;
      4'h7: clamp_active = g;
      4'h8: clamp_active = !j || !g;
      4'h9: clamp_active = !j || g;
      4'ha: clamp_active = j || !g;
      4'hb: clamp_active = j || g;
      4'hc: clamp_active = !j && !g;
      4'hd: clamp_active = !j && g;
      4'he: clamp_active = j && !g;
      4'hf: clamp_active = j && g;
      default: clamp_active = 1'b0;
    endcase
  end

  always_comb begin
    unique case (switch_mode)
      2'h0: switch_closed = 1'b0;
      2'h1: switch_closed = 1'b1;
      2'h2: switch_closed = clamp_active;
      2'h3: switch_closed = !clamp_active;
    endcase
  end
endmodule // jcmd_clamp

//--- tb/jcmd_fe_model.sv
// Analogue front-end model that answers each measurement start
`timescale 1ns/1ns
module jcmd_fe_model (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic meas_start,
  input wire logic [2:0] lvl_in,
  input wire logic [6:0] adc_in,
  output logic meas_done,
  output logic [2:0] meas_level,
  output logic [6:0] meas_adc
);
  int cnt;
  // Result lines toggle outside the done window so stale values never look valid
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 0;
      meas_done <= 1'b0;
      meas_level <= 3'h0;
      meas_adc <= 7'h00;
    end else begin
      if (meas_start) cnt <= 1;
      else if (cnt == 11) cnt <= 0;
      else if (cnt != 0) cnt <= cnt + 1;
      if (cnt == 4) begin
        meas_level <= lvl_in;
        meas_adc <= adc_in;
      end else if (cnt < 4 || cnt > 10) begin
        meas_level <= ~meas_level;
        meas_adc <= ~meas_adc;
      end
      meas_done <= (cnt >= 5 && cnt <= 10);
    end
  end
endmodule // jcmd_fe_model

//--- tb/jcmd_top_tb.sv
// Self-checking bench for the jack clamp and mic detect controller
`timescale 1ns/1ns
`include "jcmd_params.svh"
module jcmd_top_tb;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [13:0] awaddr = 14'h0000;
  logic [13:0] araddr = 14'h0000;
  logic [31:0] wdata = 32'h00000000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, meas_done, meas_start;
  logic [1:0] bresp, rresp, meas_ref_sel;
  logic [31:0] rdata, d;
  logic jack_sense = 1'b0, general_input_line = 1'b0;
  logic [2:0] meas_level, bias_enable, lvl = 3'h5;
  logic [6:0] meas_adc, adc = 7'h0a;
  logic clamp_active, switch_closed, meas_pin_sel, meas_adc_mode, ec;
  logic [1:0] r;
  logic [7:0] level_enable_mask;
  int error_cnt = 0, n_compared = 0, n;
  int per[5];
  int codes[5] = '{1, 3, 12, 13, 0};

  always #50 core_clk = ~core_clk;

  jcmd_top #(.INTERVAL_BASE_CYC(4)) uut (.core_clk(core_clk), .rst_b(rst_b),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'h3), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .jack_sense(jack_sense), .general_input_line(general_input_line),
    .meas_done(meas_done), .meas_level(meas_level), .meas_adc(meas_adc),
    .clamp_active(clamp_active), .switch_closed(switch_closed), .meas_start(meas_start),
    .meas_pin_sel(meas_pin_sel), .meas_adc_mode(meas_adc_mode), .meas_ref_sel(meas_ref_sel),
    .bias_enable(bias_enable), .level_enable_mask(level_enable_mask));

  jcmd_fe_model fe (.core_clk(core_clk), .rst_b(rst_b), .meas_start(meas_start),
    .lvl_in(lvl), .adc_in(adc), .meas_done(meas_done), .meas_level(meas_level),
    .meas_adc(meas_adc));

  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [11:0] idx, input logic [15:0] v, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge core_clk);
    awaddr <= {idx, 2'b00};
    wdata <= {16'h0000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge core_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        done = 1'b1;
        chk($sformatf("bresp %h", idx), {30'h0, bresp}, {30'h0, er});
      end
    end
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] idx, output logic [31:0] v, output logic [1:0] rr);
    logic done;
    done = 1'b0;
    @(posedge core_clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge core_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        done = 1'b1;
        v = rdata;
        rr = rresp;
      end
    end
    rready <= 1'b0;
  endtask

  task automatic rc(input logic [11:0] idx, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] v;
    logic [1:0] rr;
    rd(idx, v, rr);
    chk($sformatf("reg %h", idx), v, e);
    chk($sformatf("rresp %h", idx), {30'h0, rr}, {30'h0, er});
  endtask

  // Start pulses stand one cycle, so each edge is inspected
  task automatic wait_start();
    do @(posedge core_clk); while (meas_start !== 1'b1);
  endtask

  function automatic logic [15:0] ctl(logic en, logic dbt, logic [1:0] rf, logic [3:0] rt);
    return {4'h0, rt, 2'b00, rf, 2'b00, dbt, en};
  endfunction

  function automatic logic exp_clamp(input logic [3:0] m, input logic j, input logic g);
    case (m)
      4'h1: return 1'b1;
      4'h4: return !j;
      4'h5: return j;
      4'h6: return !g;
      4'h7: return g;
      4'h8: return !j || !g;
      4'h9: return !j || g;
      4'ha: return j || !g;
      4'hb: return j || g;
      4'hc: return !j && !g;
      4'hd: return !j && g;
      4'he: return j && !g;
      4'hf: return j && g;
      default: return 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #5000000;
    error_cnt++;
    give_verdict();
  end

  initial begin
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge core_clk);
    rc(`JCMD_IDX_DET_CTRL, 32'h0102, 2'b00);
    rc(`JCMD_IDX_LVL_MASK, 32'h00ff, 2'b00);
    rc(`JCMD_IDX_CLAMP, 32'h0, 2'b00);
    rc(`JCMD_IDX_SWITCH, 32'h0, 2'b00);
    rc(12'h100, 32'h0, 2'b10);
    wr(12'h100, 16'h0001, 2'b10);
    wr(`JCMD_IDX_RAW_STS, 16'hffff, 2'b00);
    rc(`JCMD_IDX_RAW_STS, 32'h0, 2'b00);
    wr(`JCMD_IDX_LVL_MASK, 16'h005a, 2'b00);
    chk("level mask", level_enable_mask, 32'h5a);
    for (int m = 0; m < 16; m++) begin
      wr(`JCMD_IDX_CLAMP, m[15:0], 2'b00);
      wr(`JCMD_IDX_SWITCH, {14'h0, m[1:0]}, 2'b00);
      for (int p = 0; p < 4; p++) begin
        jack_sense <= p[1];
        general_input_line <= p[0];
        repeat (6) @(posedge core_clk);
        ec = exp_clamp(m[3:0], p[1], p[0]);
        chk("clamp", clamp_active, ec);
        chk("switch", switch_closed, m[1] ? (m[0] ? !ec : ec) : m[0]);
        rc(`JCMD_IDX_RAW_STS, {30'h0, ec, p[1]}, 2'b00);
      end
    end
    // Pop suppression setup: clamp on jack low, switch follows the inverse
    wr(`JCMD_IDX_CLAMP, 16'h0004, 2'b00);
    wr(`JCMD_IDX_SWITCH, 16'h0003, 2'b00);
    jack_sense <= 1'b1;
    repeat (6) @(posedge core_clk);
    chk("clamp idle", clamp_active, 1'b0);
    wr(`JCMD_IDX_DEBOUNCE, 16'h0008, 2'b00);
    rc(`JCMD_IDX_DEBOUNCE, 32'h0008, 2'b00);
    jack_sense <= 1'b0;
    repeat (300) @(posedge core_clk);
    chk("clamp early", clamp_active, 1'b0);
    repeat (1700) @(posedge core_clk);
    chk("clamp late", clamp_active, 1'b1);
    chk("switch open", switch_closed, 1'b0);
    wr(`JCMD_IDX_DEBOUNCE, 16'h0000, 2'b00);
    // A headphone mode must not start mic measurements
    wr(`JCMD_IDX_ACC_MODE, 16'h0001, 2'b00);
    wr(`JCMD_IDX_DET_CTRL, ctl(1'b1, 1'b0, 2'h2, 4'h3), 2'b00);
    n = 0;
    repeat (100) begin
      @(posedge core_clk);
      if (meas_start === 1'b1) n++;
    end
    chk("starts gated", n, 0);
    chk("bias gated", bias_enable, 3'h0);
    wr(`JCMD_IDX_ACC_MODE, 16'h2000, 2'b00);
    for (int b = 0; b < 2; b++) begin
      wr(`JCMD_IDX_DET_CTRL, ctl(1'b0, b[0], 2'h2, 4'h3), 2'b00);
      rd(`JCMD_IDX_DET_STS, d, r);
      chk("valid off", d[0], 1'b0);
      wr(`JCMD_IDX_DET_CTRL, ctl(1'b1, b[0], 2'h2, 4'h3), 2'b00);
      chk("pin sel", meas_pin_sel, 1'b1);
      chk("ref sel", meas_ref_sel, 2'h2);
      chk("adc mode", meas_adc_mode, 1'b0);
      repeat (b ? 4 : 2) wait_start();
      chk("bias", bias_enable, 3'h2);
      rd(`JCMD_IDX_DET_STS, d, r);
      chk("valid early", d[0], 1'b0);
      wait_start();
      rd(`JCMD_IDX_DET_STS, d, r);
      chk("status", d[4:0], 5'h17);
    end
    lvl <= 3'h0;
    repeat (6) wait_start();
    rd(`JCMD_IDX_DET_STS, d, r);
    chk("status change", d[4:0], 5'h01);
    for (int i = 0; i < 5; i++) begin
      wr(`JCMD_IDX_DET_CTRL, ctl(1'b0, 1'b0, 2'h0, 4'h0), 2'b00);
      wr(`JCMD_IDX_DET_CTRL, ctl(1'b1, 1'b0, 2'(i == 1), codes[i][3:0]), 2'b00);
      wait_start();
      chk("bias rail", bias_enable, (i == 1) ? 3'h1 : 3'h0);
      per[i] = 0;
      do begin
        @(posedge core_clk);
        per[i]++;
      end while (meas_start !== 1'b1);
    end
    chk("interval 3-1", per[1] - per[0], 12);
    chk("interval 12-1", per[2] - per[0], 8188);
    chk("interval cap", per[3], per[2]);
    chk("continuous", per[4] < per[0], 1'b1);
    wr(`JCMD_IDX_DET_CTRL, ctl(1'b0, 1'b0, 2'h0, 4'h3), 2'b00);
    wr(`JCMD_IDX_ACC_MODE, 16'h0007, 2'b00);
    wr(`JCMD_IDX_DET_CTRL, ctl(1'b1, 1'b0, 2'h3, 4'h3), 2'b00);
    chk("adc mode on", meas_adc_mode, 1'b1);
    chk("bias three", bias_enable, 3'h4);
    repeat (2) wait_start();
    adc <= 7'h07;
    rd(`JCMD_IDX_DET_STS, d, r);
    chk("adc valid", d[0], 1'b1);
    wait_start();
    wr(`JCMD_IDX_DET_CTRL, ctl(1'b0, 1'b0, 2'h3, 4'h3), 2'b00);
    rc(`JCMD_IDX_ADC, 32'h7d07, 2'b00);
    give_verdict();
  end
endmodule // jcmd_top_tb
